//--- core/burner_seq_defines.svh
`ifndef BURNER_SEQ_DEFINES_SVH
`define BURNER_SEQ_DEFINES_SVH

`define TICK_HZ           32'd40_000_000
`define STAB_SHORT_S      8'd2
`define STAB_LONG_S       8'd10
`define FLAME_HOLD_MAX_S  8'd40
`define PREIGN_HOLD_MAX_S 8'd30
`define LOCKIL_HOLD_MAX_S 8'd120
`define TIMER_ZERO        8'h00
`define TIMER_ONE         8'h01

`define FAULT_NONE        8'h00
`define FAULT_NOISE       8'h01
`define FAULT_DROPOUT     8'h02
`define FAULT_FREQ        8'h03
`define FAULT_LOWV        8'h04
`define FAULT_FLAME_HOLD  8'h10
`define FAULT_PREIGN_HOLD 8'h11
`define FAULT_LOCKIL_HOLD 8'h12
`define FAULT_FALSE_FLAME 8'h20
`define FAULT_PREIGN_FAIL 8'h21
`define FAULT_LOCKIL_FAIL 8'h22
`define FAULT_INTERNAL    8'h30

`endif

//--- core/burner_seq_pkg.sv
`default_nettype none

package burner_seq_pkg;

  typedef enum logic [3:0] {
    SEQ_STANDBY,
    SEQ_PREPURGE,
    SEQ_PREIGNITION,
    SEQ_SAFETY1,
    SEQ_PILOT_IGNITION,
    SEQ_PILOT_STABILIZATION,
    SEQ_MAIN_IGNITION,
    SEQ_RUN,
    SEQ_POSTPURGE
  } seq_code_t;

  typedef enum logic [3:0] {
    HOLD_NONE,
    HOLD_STAB_TIMING,
    HOLD_NOISE,
    HOLD_DROPOUT,
    HOLD_FREQ,
    HOLD_LOWV,
    HOLD_FLAME,
    HOLD_PREIGN,
    HOLD_LOCKIL,
    HOLD_LOCKOUT
  } hold_reason_t;

  typedef struct packed {
    logic noise;
    logic dropout;
    logic freq_high;
    logic low_volt;
  } supply_t;

  typedef struct packed {
    logic burner_switch_closed;
    logic setpoint_satisfied;
    logic recycle_limit_closed;
    logic preignition_interlock_input;
    logic lockout_interlock_input;
    logic flame_present;
  } burner_in_t;

  typedef struct packed {
    seq_code_t    seq;
    hold_reason_t reason;
    logic [7:0]   fault_code;
    logic         initiate;
    logic         lockout;
  } status_t;

endpackage

`default_nettype wire

//--- core/hold_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "burner_seq_defines.svh"

// Counts whole seconds while a hold runs and clears when it ends.
module hold_timer
  import burner_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_limit,
  // Result
  output logic      [7:0] o_count,
  output logic            o_expired
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic       at_limit;

  assign at_limit   = (count >= i_limit);
  assign next_count = !i_run ? `TIMER_ZERO :
                      (i_tick && !at_limit) ? count + `TIMER_ONE : count; // [R15]

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      count <= `TIMER_ZERO;
    else
      count <= next_count;
  end

  assign o_count   = count;
  assign o_expired = i_run && at_limit;

  chk_timer_clears: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_run |=> count == `TIMER_ZERO) // [R15]
    else $error("hold timer did not clear");

  chk_timer_steps: assert property (@(posedge i_clk) disable iff (i_reset)
    i_run && $past(i_run) && i_tick && !at_limit |=> count == $past(count) + `TIMER_ONE) // [R15]
    else $error("hold timer did not count tick");

endmodule
`default_nettype wire

//--- core/burner_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "burner_seq_defines.svh"

// Operation
// R1: Stabilize two or ten seconds, then idle.
// R2: Line noise holds stabilization, noise reason.
// R3: Dropout holds until full stable period.
// R4: High frequency holds until frequency proper.
// R5: Low voltage holds until voltage sufficient.
// R6: Switch open or setpoint satisfied gives idle.
// R7: Demand waits in idle for recycle limit.
// R8: Flame in idle holds; lockout after 40s.
// R9: Pre-ignition interlock open; lockout after 30s.
// R10: Lockout interlock closed holds idle.
// R11: Lockout interlock hold over 120s locks out.
// R12: Report state as one of nine codes.
// R13: Output fault code with hold reason.
// R14: Report internal and external faults.
// R15: Hold timers count seconds, restart, clear.
// R16: Lockout persists until external reset request.
module burner_sequencer
  import burner_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Timing and model
  input  wire logic       i_second_tick,
  input  wire logic       i_long_stab_model,
  // Supply monitor and burner inputs
  input  wire supply_t    i_supply,
  input  wire burner_in_t i_burner,
  input  wire logic       i_internal_fault,
  input  wire logic       i_lockout_reset_req,
  // Status to display
  output status_t         o_status,
  output logic            o_advance_to_purge
);

  typedef enum logic [1:0] {ST_INITIATE, ST_STANDBY, ST_LOCKOUT} phase_t;

  phase_t       phase;
  phase_t       next_phase;
  hold_reason_t reason;
  hold_reason_t next_reason;
  logic [7:0]   fault_code;
  logic [7:0]   next_fault_code;
  logic [7:0]   stab_len;
  logic         long_model;

  // Model strap sampled by the clock while reset is held.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      long_model <= i_long_stab_model;
  end

  assign stab_len = long_model ? `STAB_LONG_S : `STAB_SHORT_S; // [R1]

  wire supply_bad = i_supply.noise || i_supply.dropout ||
                    i_supply.freq_high || i_supply.low_volt;
  wire in_init    = (phase == ST_INITIATE);
  wire in_standby = (phase == ST_STANDBY);
  wire demand     = i_burner.burner_switch_closed && !i_burner.setpoint_satisfied; // [R6]
  wire hold_flame  = in_standby && demand && i_burner.flame_present; // [R8]
  wire hold_preign = in_standby && demand && !i_burner.flame_present &&
                     !i_burner.preignition_interlock_input; // [R9]
  wire hold_lockil = in_standby && demand && !i_burner.flame_present &&
                     i_burner.preignition_interlock_input &&
                     i_burner.lockout_interlock_input; // [R10]

  // The stabilization timer restarts on any disturbance, so a dropout needs
  // a whole clean period before idle is reached.
  wire        stab_run = in_init && !supply_bad; // [R3]
  wire [7:0]  stab_count;
  wire        stab_done;
  wire        flame_exp;
  wire        preign_exp;
  wire        lockil_exp;

  hold_timer u_stab (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_run     (stab_run),
    .i_tick    (i_second_tick),
    .i_limit   (stab_len),
    .o_count   (stab_count),
    .o_expired (stab_done)
  );

  hold_timer u_flame (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_run     (hold_flame),
    .i_tick    (i_second_tick),
    .i_limit   (`FLAME_HOLD_MAX_S),
    .o_count   (),
    .o_expired (flame_exp)
  );

  hold_timer u_preign (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_run     (hold_preign),
    .i_tick    (i_second_tick),
    .i_limit   (`PREIGN_HOLD_MAX_S),
    .o_count   (),
    .o_expired (preign_exp)
  );

  hold_timer u_lockil (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_run     (hold_lockil),
    .i_tick    (i_second_tick),
    .i_limit   (`LOCKIL_HOLD_MAX_S),
    .o_count   (),
    .o_expired (lockil_exp)
  );

  // Expiry at the limit plus one further tick means the hold lasted longer.
  wire flame_trip  = flame_exp && i_second_tick; // [R8]
  wire preign_trip = preign_exp && i_second_tick; // [R9]
  wire lockil_trip = lockil_exp && i_second_tick; // [R11]

  // Supply reason priority: noise, dropout, frequency, low voltage.
  wire hold_reason_t supply_reason =
    i_supply.noise     ? HOLD_NOISE   : // [R2]
    i_supply.dropout   ? HOLD_DROPOUT : // [R3]
    i_supply.freq_high ? HOLD_FREQ    : // [R4]
    i_supply.low_volt  ? HOLD_LOWV    : // [R5]
                         HOLD_STAB_TIMING;

  wire [7:0] supply_code =
    i_supply.noise     ? `FAULT_NOISE   :
    i_supply.dropout   ? `FAULT_DROPOUT :
    i_supply.freq_high ? `FAULT_FREQ    :
    i_supply.low_volt  ? `FAULT_LOWV    : `FAULT_NONE;

  wire hold_reason_t standby_reason =
    hold_flame  ? HOLD_FLAME  :
    hold_preign ? HOLD_PREIGN :
    hold_lockil ? HOLD_LOCKIL : HOLD_NONE;

  wire [7:0] standby_code =
    hold_flame  ? `FAULT_FLAME_HOLD  :
    hold_preign ? `FAULT_PREIGN_HOLD :
    hold_lockil ? `FAULT_LOCKIL_HOLD : `FAULT_NONE;

  wire [7:0] trip_code =
    i_internal_fault ? `FAULT_INTERNAL    : // [R14]
    flame_trip       ? `FAULT_FALSE_FLAME :
    preign_trip      ? `FAULT_PREIGN_FAIL : `FAULT_LOCKIL_FAIL;

  wire trip = i_internal_fault || flame_trip || preign_trip || lockil_trip; // [R14]

  always_comb
  begin
    next_phase      = phase;
    next_reason     = reason;
    next_fault_code = fault_code;
    case (phase)
      ST_INITIATE:
      begin
        next_reason     = supply_reason; // [R13]
        next_fault_code = supply_code;
        if (i_internal_fault)
        begin
          next_phase      = ST_LOCKOUT;
          next_reason     = HOLD_LOCKOUT;
          next_fault_code = `FAULT_INTERNAL;
        end
        else if (stab_done && !supply_bad)
        begin
          next_phase      = ST_STANDBY; // [R1]
          next_reason     = HOLD_NONE;
          next_fault_code = `FAULT_NONE;
        end
      end
      ST_STANDBY:
      begin
        next_reason     = standby_reason; // [R13]
        next_fault_code = standby_code;
        if (trip)
        begin
          next_phase      = ST_LOCKOUT;
          next_reason     = HOLD_LOCKOUT;
          next_fault_code = trip_code;
        end
        else if (supply_bad)
        begin
          next_phase      = ST_INITIATE; // [R1]
          next_reason     = supply_reason;
          next_fault_code = supply_code;
        end
      end
      ST_LOCKOUT:
      begin
        if (i_lockout_reset_req)
        begin
          next_phase      = ST_INITIATE; // [R16]
          next_reason     = HOLD_STAB_TIMING;
          next_fault_code = `FAULT_NONE;
        end
      end
      default:
      begin
        next_phase = ST_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      phase      <= ST_INITIATE;
      reason     <= HOLD_STAB_TIMING;
      fault_code <= `FAULT_NONE;
    end
    else
    begin
      phase      <= next_phase;
      reason     <= next_reason;
      fault_code <= next_fault_code;
    end
  end

  // Only idle is reachable here; the later codes come from downstream stages.
  assign o_status.seq        = SEQ_STANDBY; // [R12]
  assign o_status.reason     = reason;
  assign o_status.fault_code = fault_code; // [R13]
  assign o_status.initiate   = in_init;
  assign o_status.lockout    = (phase == ST_LOCKOUT);

  // Advance only with demand, recycle limit closed and no hold.
  assign o_advance_to_purge = in_standby && demand && !trip && !supply_bad &&
                              i_burner.recycle_limit_closed && // [R7]
                              !hold_flame && !hold_preign && !hold_lockil; // [R10]

  chk_noise_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
    in_init && i_supply.noise |=> phase != ST_STANDBY) // [R2]
    else $error("advanced to idle during line noise");

  chk_noise_reason: assert property (@(posedge i_clk) disable iff (i_reset)
    in_init && i_supply.noise && !i_internal_fault |=> reason == HOLD_NOISE) // [R2]
    else $error("noise reason missing");

  chk_dropout_reason: assert property (@(posedge i_clk) disable iff (i_reset)
    in_init && !i_supply.noise && i_supply.dropout && !i_internal_fault
    |=> reason == HOLD_DROPOUT) // [R3]
    else $error("dropout reason missing");

  chk_freq_reason: assert property (@(posedge i_clk) disable iff (i_reset)
    in_init && i_supply.freq_high && !i_supply.noise && !i_supply.dropout &&
    !i_internal_fault |=> reason == HOLD_FREQ) // [R4]
    else $error("frequency reason missing");

  chk_lowv_reason: assert property (@(posedge i_clk) disable iff (i_reset)
    in_init && i_supply.low_volt && !i_supply.noise && !i_supply.dropout &&
    !i_supply.freq_high && !i_internal_fault |=> reason == HOLD_LOWV) // [R5]
    else $error("low voltage reason missing");

  chk_stab_length: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(in_standby) |-> $past(stab_count) == stab_len) // [R1]
    else $error("stabilization period wrong");

  chk_no_demand_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !demand |-> !o_advance_to_purge) // [R6]
    else $error("advanced without demand");

  chk_recycle_wait: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_burner.recycle_limit_closed |-> !o_advance_to_purge) // [R7]
    else $error("advanced with recycle limit open");

  chk_flame_lock: assert property (@(posedge i_clk) disable iff (i_reset)
    flame_trip && in_standby && !i_internal_fault
    |=> phase == ST_LOCKOUT && fault_code == `FAULT_FALSE_FLAME) // [R8]
    else $error("flame hold did not lock out");

  chk_preign_lock: assert property (@(posedge i_clk) disable iff (i_reset)
    preign_trip && in_standby && !i_internal_fault
    |=> phase == ST_LOCKOUT && fault_code == `FAULT_PREIGN_FAIL) // [R9]
    else $error("pre-ignition hold did not lock out");

  chk_lockil_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    hold_lockil |-> !o_advance_to_purge) // [R10]
    else $error("advanced with lockout interlock closed");

  chk_lockil_lock: assert property (@(posedge i_clk) disable iff (i_reset)
    lockil_trip && in_standby && !i_internal_fault && !flame_trip && !preign_trip
    |=> phase == ST_LOCKOUT && fault_code == `FAULT_LOCKIL_FAIL) // [R11]
    else $error("lockout interlock hold did not lock out");

  chk_internal_fault: assert property (@(posedge i_clk) disable iff (i_reset)
    i_internal_fault && phase != ST_LOCKOUT |=> fault_code == `FAULT_INTERNAL) // [R14]
    else $error("internal fault not reported");

  chk_lockout_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    phase == ST_LOCKOUT && !i_lockout_reset_req |=> phase == ST_LOCKOUT &&
    $stable(fault_code)) // [R16]
    else $error("lockout left without reset request");

  cov_to_standby: cover property (@(posedge i_clk) disable iff (i_reset) $rose(in_standby));
  cov_advance:    cover property (@(posedge i_clk) disable iff (i_reset) o_advance_to_purge);
  cov_lockout:    cover property (@(posedge i_clk) disable iff (i_reset)
    phase == ST_LOCKOUT ##1 i_lockout_reset_req);

endmodule
`default_nettype wire

//--- tb/burner_field_model.sv
`timescale 1ns/100ps
`default_nettype none

// Supply monitor tick, scaled down so that one second lasts TICK_CYC clocks.
module burner_field_model
#(
  parameter int TICK_CYC = 20
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Tick
  output logic      o_second_tick = 1'b0
);
  int cnt = 0;

  always @(negedge i_clk)
  begin
    if (i_reset || cnt == TICK_CYC - 1)
      cnt <= 0;
    else
      cnt <= cnt + 1;
    o_second_tick <= !i_reset && cnt == TICK_CYC - 1;
  end
endmodule

`default_nettype wire

//--- tb/burner_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "burner_seq_defines.svh"

module burner_sequencer_tb;
  import burner_seq_pkg::*;

  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_long_stab_model = 1'b0;
  logic       i_internal_fault = 1'b0;
  logic       i_lockout_reset_req = 1'b0;
  logic       tick;
  supply_t    i_supply = '0;
  // Bits: switch, setpoint, recycle, pre-ignition, lockout interlock, flame.
  burner_in_t i_burner = 6'b101100;
  status_t    o_status;
  logic       o_advance_to_purge;
  int         fails = 0;
  int         checked = 0;

  burner_field_model #(.TICK_CYC(20)) u_burner_field_model
  (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .o_second_tick (tick)
  );

  burner_sequencer u_burner_sequencer
  (
    .i_clk               (i_clk),
    .i_reset             (i_reset),
    .i_second_tick       (tick),
    .i_long_stab_model   (i_long_stab_model),
    .i_supply            (i_supply),
    .i_burner            (i_burner),
    .i_internal_fault    (i_internal_fault),
    .i_lockout_reset_req (i_lockout_reset_req),
    .o_status            (o_status),
    .o_advance_to_purge  (o_advance_to_purge)
  );

  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // The margin of three clocks lets the tick's count and the state land.
  task automatic ticks(input int n);
    repeat (n) @(posedge tick);
    cyc(3);
  endtask

  task automatic t_stab(input logic long_stab, input int n);
    i_reset = 1'b1;
    i_long_stab_model = long_stab;
    cyc(4);
    i_reset = 1'b0;
    cyc(1);
    chk(o_status.initiate === 1'b1 && o_status.reason === HOLD_STAB_TIMING, "reset");
    chk(o_status.fault_code === `FAULT_NONE && o_advance_to_purge === 1'b0, "rst out");
    ticks(n - 1);
    chk(o_status.initiate === 1'b1, "stab early");
    ticks(1);
    chk(o_status.initiate === 1'b0 && o_status.reason === HOLD_NONE, "stab end");
    chk(o_status.seq === SEQ_STANDBY, "idle code");
  endtask

  task automatic t_supply();
    hold_reason_t rs [4] = '{HOLD_NOISE, HOLD_DROPOUT, HOLD_FREQ, HOLD_LOWV};
    logic [7:0]   fc [4] = '{`FAULT_NOISE, `FAULT_DROPOUT, `FAULT_FREQ, `FAULT_LOWV};
    for (int i = 0; i < 4; i++)
    begin
      // Low voltage rides along to check the reason priority.
      i_supply = (4'b1000 >> i) | 4'b0001;
      cyc(2);
      chk(o_status.initiate === 1'b1 && o_status.reason === rs[i], "reason");
      chk(o_status.fault_code === fc[i], "supply code");
      ticks(12);
      chk(o_status.initiate === 1'b1 && o_advance_to_purge === 1'b0, "held");
      i_supply = '0;
      ticks(1);
      if (i == 1)
        chk(o_status.initiate === 1'b1, "restab");
      ticks(1);
      chk(o_status.initiate === 1'b0, "supply clear");
    end
  endtask

  task automatic t_adv();
    logic [5:0] pat [4] = '{6'b101100, 6'b100100, 6'b001100, 6'b111100};
    for (int i = 0; i < 4; i++)
    begin
      i_burner = pat[i];
      cyc(2);
      chk(o_advance_to_purge === (i == 0) && o_status.reason === HOLD_NONE, "adv");
    end
  endtask

  task automatic clear_lock();
    i_lockout_reset_req = 1'b1;
    cyc(1);
    i_lockout_reset_req = 1'b0;
    cyc(1);
    chk(o_status.lockout === 1'b0 && o_status.initiate === 1'b1, "reset req");
    ticks(3);
  endtask

  task automatic t_hold(input int k);
    logic [5:0]   pat [3] = '{6'b101101, 6'b101000, 6'b101110};
    int           lim [3] = '{40, 30, 120};
    hold_reason_t rs [3] = '{HOLD_FLAME, HOLD_PREIGN, HOLD_LOCKIL};
    logic [7:0]   hc [3] = '{`FAULT_FLAME_HOLD, `FAULT_PREIGN_HOLD, `FAULT_LOCKIL_HOLD};
    logic [7:0]   tc [3] = '{`FAULT_FALSE_FLAME, `FAULT_PREIGN_FAIL, `FAULT_LOCKIL_FAIL};
    i_burner = pat[k];
    ticks(lim[k] - 5);
    i_burner = 6'b101100;
    cyc(3);
    chk(o_status.reason === HOLD_NONE && o_advance_to_purge === 1'b1, "hold gone");
    i_burner = pat[k];
    cyc(2);
    chk(o_status.reason === rs[k] && o_status.fault_code === hc[k], "hold");
    chk(o_advance_to_purge === 1'b0 && o_status.initiate === 1'b0, "no adv");
    ticks(lim[k]);
    chk(o_status.lockout === 1'b0, "early trip");
    ticks(1);
    chk(o_status.lockout === 1'b1 && o_status.fault_code === tc[k], "trip");
    chk(o_status.reason === HOLD_LOCKOUT, "lock reason");
    i_burner = 6'b101100;
    ticks(2);
    chk(o_status.lockout === 1'b1 && o_status.fault_code === tc[k], "kept");
    clear_lock();
  endtask

  task automatic t_internal();
    i_internal_fault = 1'b1;
    cyc(2);
    i_internal_fault = 1'b0;
    cyc(2);
    chk(o_status.lockout === 1'b1 && o_status.fault_code === `FAULT_INTERNAL, "int");
    clear_lock();
  endtask

  initial
  begin
    t_stab(1'b0, 2);
    t_supply();
    t_adv();
    for (int k = 0; k < 3; k++)
      t_hold(k);
    t_internal();
    t_stab(1'b1, 10);
    tally_and_finish();
  end

  initial
  begin
    #1ms;
    fails++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
